// *** hw/bbhp_host_port.sv ***
// Host-facing port of the bubble memory expansion board
`timescale 1ns/100ps
`default_nettype none
`include "bbhp_defs.svh"

// Contract
// R1 - Jumper picks DMA or interrupt wiring; software picks that mode or polling.
// R2 - DMA transfers only when enable register bit 2 is one.
// R3 - Host loads its DMA controller count and address, extended write advised.
// R4 - Host checks busy is zero, loads parameters, then writes command.
// R5 - While busy only abort is accepted; other commands are dropped. Code also acts on clear command 20h while busy.
// R6 - Host should abort before initialize at power-up.
// R7 - Host counts bytes itself; early busy clear is an error.
// R8 - Interrupt reports done, fail or data error per enable bits.
// R9 - Done marks bubble side end; busy holds until FIFO drained.
// R10 - Command 20h clears interrupt pin and status flags.
// R11 - Active low strobes act only with select zero low.
// R12 - Active high DMA request, active low grant, one byte per cycle.
// R13 - Initialize line forces a known state.
// R14 - Board present output is always driven low.
// R15 - Only the lowest address line and select zero are decoded.
// R16 - Base board decodes upper address bits into module selects.
// R17 - Address high hits command/pointer/status; low hits pointed secondary register.
// R18 - Eight data lines active high, line zero least significant.
// R19 - Only first interrupt line used, in data request interrupt mode.
// R20 - First option line carries ninth data bit; second a test clock.
// R21 - During DMA the grant alone selects the FIFO; select and address ignored.
// R22 - Request drops during a granted cycle to end DMA.
// R23 - Clear command points pointer at FIFO, leaves data request untouched.
// R24 - Host strobes pass two flip-flops before their edges are used.
module bbhp_host_port
  import bbhp_pkg::*;
(
  input  wire logic           ref_clk,
  input  wire logic           rst,
  input  wire logic           host_read_strobe_n,
  input  wire logic           host_write_strobe_n,
  input  wire logic           module_select_zero_n,
  input  wire logic           register_bank_select,
  input  wire bbhp_pkg::bbhp_byte_t host_data_in,
  output var  bbhp_pkg::bbhp_byte_t host_data_out,
  output var  logic           host_data_oe,
  output var  logic           dma_request_out,
  input  wire logic           dma_grant_in_n,
  output var  logic           module_present_n,
  output var  logic           irq_line_zero,
  output var  logic           irq_line_one,
  output var  logic           parity_option_line,
  output var  logic           test_clock_option_line,
  input  wire logic           dmaJumper,
  input  wire logic           ctrlBusy,
  input  wire logic           ctrlXferRequest,
  input  wire logic           ctrlDoneEvt,
  input  wire logic           ctrlFailEvt,
  input  wire logic           ctrlErrEvt,
  input  wire bbhp_pkg::bbhp_byte_t ctrlRdData,
  input  wire logic           ninthDataBit,
  output var  logic           ctrlCmdPulse,
  output var  bbhp_pkg::bbhp_byte_t ctrlCmdCode,
  output var  logic           ctrlRegWr,
  output var  logic           ctrlRegRd,
  output var  bbhp_pkg::bbhp_idx_t  ctrlRegIdx,
  output var  bbhp_pkg::bbhp_byte_t ctrlRegWrData
);
  import bbhp_pkg::*;

  bbhp_state_s s_ff;
  bbhp_state_s nxt_s;
  logic        rdFall;
  logic        wrRise;
  logic        clrCmd;
  bbhp_byte_t  status;

  always_comb
  begin
    nxt_s = s_ff;
    // Two-stage synchronisers
    nxt_s.rdS1  = host_read_strobe_n;                 // see R24
    nxt_s.rdS2  = s_ff.rdS1;
    nxt_s.rdD   = s_ff.rdS2;
    nxt_s.wrS1  = host_write_strobe_n;                // see R24
    nxt_s.wrS2  = s_ff.wrS1;
    nxt_s.wrD   = s_ff.wrS2;
    nxt_s.csS1  = module_select_zero_n;               // see R15
    nxt_s.csS2  = s_ff.csS1;
    nxt_s.a0S1  = register_bank_select;
    nxt_s.a0S2  = s_ff.a0S1;
    nxt_s.ackS1 = dma_grant_in_n;
    nxt_s.ackS2 = s_ff.ackS1;
    nxt_s.dS1   = host_data_in;                       // see R18
    nxt_s.dS2   = s_ff.dS1;
    nxt_s.cmdPulse = 1'b0;
    nxt_s.regWr    = 1'b0;
    nxt_s.regRd    = 1'b0;
    nxt_s.tclk     = ~s_ff.tclk;                      // see R20
    nxt_s.par      = ninthDataBit;                    // see R20

    status = 8'h00;
    status[`BBHP_ST_BUSY_BIT] = ctrlBusy;
    status[`BBHP_ST_DONE_BIT] = s_ff.stDone;
    status[`BBHP_ST_FAIL_BIT] = s_ff.stFail;
    status[`BBHP_ST_ERR_BIT]  = s_ff.stErr;
    status[`BBHP_ST_XREQ_BIT] = ctrlXferRequest;

    rdFall = s_ff.rdD & ~s_ff.rdS2;
    wrRise = ~s_ff.wrD & s_ff.wrS2;
    clrCmd = 1'b0;

    // Write strobe low: keep latest data and select
    if (!s_ff.wrS2)
    begin
      nxt_s.capData = s_ff.dS2;
      nxt_s.capA0   = s_ff.a0S2;
      nxt_s.capCs   = s_ff.csS2;
      nxt_s.capAck  = s_ff.ackS2;
    end

    // Read access
    if (rdFall && !s_ff.ackS2)
    begin
      nxt_s.dataOe  = 1'b1;                           // see R21
      nxt_s.dataOut = ctrlRdData;
      nxt_s.regRd   = 1'b1;
      nxt_s.regIdx  = `BBHP_IDX_FIFO;
    end
    else if (rdFall && !s_ff.csS2)                    // see R11
    begin
      nxt_s.dataOe = 1'b1;
      if (s_ff.a0S2)
        nxt_s.dataOut = status;                       // see R17
      else
      begin
        nxt_s.dataOut = (s_ff.ptr == `BBHP_IDX_ENABLE) ? s_ff.enReg : ctrlRdData;
        nxt_s.regRd   = 1'b1;
        nxt_s.regIdx  = s_ff.ptr;
        if (s_ff.ptr != `BBHP_IDX_FIFO)
          nxt_s.ptr = s_ff.ptr + 4'h1;
      end
    end
    if (s_ff.rdS2)
      nxt_s.dataOe = 1'b0;

    // Write access
    if (wrRise && !s_ff.capAck)
    begin
      nxt_s.regWr   = 1'b1;                           // see R21
      nxt_s.regIdx  = `BBHP_IDX_FIFO;
      nxt_s.regData = s_ff.capData;
    end
    else if (wrRise && !s_ff.capCs)                   // see R11
    begin
      if (s_ff.capA0)
      begin
        if (s_ff.capData[7:4] == 4'h0)
          nxt_s.ptr = s_ff.capData[3:0];              // see R17
        else if (s_ff.capData == `BBHP_CMD_CLEAR_INT)
        begin
          clrCmd    = 1'b1;                           // see R10
          nxt_s.ptr = `BBHP_IDX_FIFO;                 // see R23
        end
        else if (!ctrlBusy || s_ff.capData == `BBHP_CMD_ABORT)
        begin
          nxt_s.cmdPulse = 1'b1;                      // see R5
          nxt_s.cmdCode  = s_ff.capData;
        end
      end
      else
      begin
        nxt_s.regWr   = 1'b1;                         // see R17
        nxt_s.regIdx  = s_ff.ptr;
        nxt_s.regData = s_ff.capData;
        if (s_ff.ptr == `BBHP_IDX_ENABLE)
          nxt_s.enReg = s_ff.capData;
        if (s_ff.ptr != `BBHP_IDX_FIFO)
          nxt_s.ptr = s_ff.ptr + 4'h1;
      end
    end

    // Sticky status: set wins over clear
    nxt_s.stDone = (s_ff.stDone & ~clrCmd) | ctrlDoneEvt;   // see R9
    nxt_s.stFail = (s_ff.stFail & ~clrCmd) | ctrlFailEvt;
    nxt_s.stErr  = (s_ff.stErr & ~clrCmd) | ctrlErrEvt;

    // Interrupt only on the interrupt wiring
    nxt_s.irq0 = ~dmaJumper &
                 ((s_ff.enReg[`BBHP_EN_DONE_BIT] & s_ff.stDone) |
                  (s_ff.enReg[`BBHP_EN_ERR_BIT] & (s_ff.stFail | s_ff.stErr)) |
                  (s_ff.enReg[`BBHP_EN_XREQ_BIT] & ~s_ff.enReg[`BBHP_EN_DMA_BIT] &
                   ctrlXferRequest));                 // see R8, R19, R1

    // DMA request, dropped within each granted cycle
    if (!s_ff.ackS2 && (!s_ff.rdS2 || !s_ff.wrS2))
      nxt_s.dmaHold = 1'b1;                           // see R22
    else if (s_ff.ackS2)
      nxt_s.dmaHold = 1'b0;
    nxt_s.dreq = dmaJumper & s_ff.enReg[`BBHP_EN_DMA_BIT] & ctrlXferRequest &
                 ~nxt_s.dmaHold;                      // see R2, R12, R1
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_ff       <= '0;                               // see R13
      s_ff.rdS1  <= 1'b1;
      s_ff.rdS2  <= 1'b1;
      s_ff.rdD   <= 1'b1;
      s_ff.wrS1  <= 1'b1;
      s_ff.wrS2  <= 1'b1;
      s_ff.wrD   <= 1'b1;
      s_ff.csS1  <= 1'b1;
      s_ff.csS2  <= 1'b1;
      s_ff.ackS1 <= 1'b1;
      s_ff.ackS2 <= 1'b1;
      s_ff.capCs <= 1'b1;
      s_ff.capAck <= 1'b1;
      s_ff.enReg <= `BBHP_ENABLE_RST;
    end
    else
      s_ff <= nxt_s;
  end

  assign host_data_out          = s_ff.dataOut;
  assign host_data_oe           = s_ff.dataOe;
  assign dma_request_out        = s_ff.dreq;
  assign module_present_n       = 1'b0;               // see R14
  assign irq_line_zero          = s_ff.irq0;
  assign irq_line_one           = 1'b0;               // see R19
  assign parity_option_line     = s_ff.par;
  assign test_clock_option_line = s_ff.tclk;
  assign ctrlCmdPulse           = s_ff.cmdPulse;
  assign ctrlCmdCode            = s_ff.cmdCode;
  assign ctrlRegWr              = s_ff.regWr;
  assign ctrlRegRd              = s_ff.regRd;
  assign ctrlRegIdx             = s_ff.regIdx;
  assign ctrlRegWrData          = s_ff.regData;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence hostRead;
    rdFall && !s_ff.csS2 && s_ff.ackS2;
  endsequence
  sequence clearWrite;
    wrRise && s_ff.capAck && !s_ff.capCs && s_ff.capA0 &&
    s_ff.capData == `BBHP_CMD_CLEAR_INT;
  endsequence

  a_read_drives: assert property (hostRead |=> host_data_oe ##0 rdFall == 1'b0) // see R11
    else $error("Selected read did not drive data");
  a_unselected_quiet: assert property (rdFall && s_ff.csS2 && s_ff.ackS2 |=> !host_data_oe) // see R15
    else $error("Unselected read drove data");
  a_clear_flags: assert property (clearWrite ##0 !ctrlDoneEvt |=> !s_ff.stDone) // see R10
    else $error("Clear command left done flag set");
  a_clear_ptr: assert property (clearWrite |=> s_ff.ptr == `BBHP_IDX_FIFO) // see R23
    else $error("Clear command did not point at FIFO");
  a_busy_blocks: assert property (wrRise && s_ff.capAck && !s_ff.capCs && s_ff.capA0 &&
    ctrlBusy && s_ff.capData[7:4] != 4'h0 && s_ff.capData != `BBHP_CMD_ABORT
    |=> !ctrlCmdPulse) // see R5
    else $error("Command accepted while busy");
  a_dma_enable: assert property (!s_ff.enReg[`BBHP_EN_DMA_BIT] |=> !dma_request_out) // see R2
    else $error("DMA request without enable bit");
  a_dma_drop: assert property (!s_ff.ackS2 && !s_ff.rdS2 |=> !dma_request_out) // see R22
    else $error("DMA request held during granted cycle");
  a_present_low: assert property (module_present_n == 1'b0 && irq_line_one == 1'b0) // see R14
    else $error("Present or spare interrupt line not low");
  a_irq_jumper: assert property (dmaJumper |=> !irq_line_zero) // see R19
    else $error("Interrupt raised on DMA wiring");
endmodule
`default_nettype wire

// *** hw/bbhp_defs.svh ***
// Constants for the bubble board host port
`ifndef BBHP_DEFS_SVH
`define BBHP_DEFS_SVH

`define BBHP_IDX_FIFO      4'h0
`define BBHP_IDX_ENABLE    4'hB
`define BBHP_CMD_ABORT     8'h19
`define BBHP_CMD_CLEAR_INT 8'h20
`define BBHP_EN_DONE_BIT   0
`define BBHP_EN_ERR_BIT    1
`define BBHP_EN_DMA_BIT    2
`define BBHP_EN_XREQ_BIT   3
`define BBHP_ST_BUSY_BIT   7
`define BBHP_ST_DONE_BIT   6
`define BBHP_ST_FAIL_BIT   5
`define BBHP_ST_ERR_BIT    4
`define BBHP_ST_XREQ_BIT   3
`define BBHP_ENABLE_RST    8'h00

`endif

// *** hw/bbhp_pkg.sv ***
// Types for the bubble board host port
package bbhp_pkg;

  typedef logic [7:0] bbhp_byte_t;
  typedef logic [3:0] bbhp_idx_t;

  typedef struct packed {
    logic       rdS1, rdS2, rdD;
    logic       wrS1, wrS2, wrD;
    logic       csS1, csS2;
    logic       a0S1, a0S2;
    logic       ackS1, ackS2;
    bbhp_byte_t dS1, dS2;
    bbhp_byte_t capData;
    logic       capA0, capCs, capAck;
    logic       dataOe;
    bbhp_byte_t dataOut;
    bbhp_idx_t  ptr;
    bbhp_byte_t enReg;
    logic       stDone, stFail, stErr;
    logic       irq0;
    logic       dreq;
    logic       dmaHold;
    logic       cmdPulse;
    bbhp_byte_t cmdCode;
    logic       regWr, regRd;
    bbhp_idx_t  regIdx;
    bbhp_byte_t regData;
    logic       tclk;
    logic       par;
  } bbhp_state_s;

endpackage

// *** sim/bbhp_host_model.sv ***
// Host CPU and DMA controller model on the expansion bus
`timescale 1ns/100ps
`default_nettype none
module bbhp_host_model
(
  input  wire logic                 ref_clk,
  output var  logic                 host_read_strobe_n,
  output var  logic                 host_write_strobe_n,
  output var  logic                 module_select_zero_n,
  output var  logic                 register_bank_select,
  output var  logic                 dma_grant_in_n,
  output var  bbhp_pkg::bbhp_byte_t host_data_in,
  input  wire bbhp_pkg::bbhp_byte_t host_data_out,
  input  wire logic                 host_data_oe,
  input  wire logic                 dma_request_out
);
  import bbhp_pkg::*;
  bbhp_byte_t wrData = 8'h00;
  bbhp_byte_t lastV  = 8'h00;
  logic       wrEn   = 1'b0;
  initial
  begin
    host_read_strobe_n   = 1'b1;
    host_write_strobe_n  = 1'b1;
    module_select_zero_n = 1'b1;
    register_bank_select = 1'b0;
    dma_grant_in_n       = 1'b1;
  end
  // Released bus shows a changing pattern
  always_comb
  begin
    if (wrEn)
      host_data_in = wrData;
    else if (host_data_oe === 1'b1)
      host_data_in = host_data_out;
    else
      host_data_in = ~lastV;
  end
  always @(posedge ref_clk)
    lastV <= host_data_in;
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Byte write, held well past the take
  task automatic hostWrite(input logic a0, input logic selN, input bbhp_byte_t v);
    cyc(1);
    register_bank_select = a0;
    module_select_zero_n = selN;
    wrData = v;
    wrEn = 1'b1;
    cyc(1);
    host_write_strobe_n = 1'b0;
    cyc(4);
    host_write_strobe_n = 1'b1;
    cyc(5);
    module_select_zero_n = 1'b1;
    wrEn = 1'b0;
    cyc(3);
  endtask
  // Byte read; a DMA cycle leaves select idle and address wrong
  task automatic hostRead(input logic a0, input logic dma, input logic selN,
                          output bbhp_byte_t v, output logic ok, output logic rq);
    int i;
    cyc(1);
    register_bank_select = a0;
    module_select_zero_n = selN;
    dma_grant_in_n = ~dma;
    cyc(1);
    host_read_strobe_n = 1'b0;
    i = 0;
    while (host_data_oe !== 1'b1 && i < 10)
    begin
      cyc(1);
      i++;
    end
    ok = (host_data_oe === 1'b1);
    v = host_data_out;
    cyc(2);
    rq = dma_request_out;
    host_read_strobe_n = 1'b1;
    cyc(4);
    module_select_zero_n = 1'b1;
    dma_grant_in_n = 1'b1;
    cyc(3);
  endtask
endmodule
`default_nettype wire

// *** sim/bbhp_tb.sv ***
// Self-checking bench for the bubble board host port
`timescale 1ns/100ps
`default_nettype none
`include "bbhp_defs.svh"
`define CHK(nm, ex, gt) \
  begin \
    n_tests++; \
    if ((gt) !== (ex)) \
    begin \
      mismatches++; \
      $display("MISMATCH %s expected %h seen %h", nm, ex, gt); \
    end \
  end
module tb;
  import bbhp_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        jmp = 1'b0;
  logic        busy = 1'b0;
  logic        xreq = 1'b0;
  logic [2:0]  evt = 3'b000;
  logic        nb = 1'b0;
  bbhp_byte_t  rdData = 8'h00;
  wire logic   rdN, wrN, selN, bank, gntN, dOe, dreq, prN, irq0, irq1, par, tclk;
  wire logic   cmdP, regWr, regRd;
  wire bbhp_byte_t dIn, dOut, cmdCode, wrD;
  wire bbhp_idx_t  idx;
  int          mismatches = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          nCmd = 0;
  int          nWr = 0;
  bbhp_byte_t  lastCmd, d;
  logic [11:0] lastWr;
  bbhp_idx_t   lastRd;
  logic        ok, rq, t;
  always #50 ref_clk = ~ref_clk;
  bbhp_host_model hostU (.ref_clk(ref_clk), .host_read_strobe_n(rdN),
    .host_write_strobe_n(wrN), .module_select_zero_n(selN), .register_bank_select(bank),
    .dma_grant_in_n(gntN), .host_data_in(dIn), .host_data_out(dOut), .host_data_oe(dOe),
    .dma_request_out(dreq));
  bbhp_host_port dut_u (.ref_clk(ref_clk), .rst(rst), .host_read_strobe_n(rdN),
    .host_write_strobe_n(wrN), .module_select_zero_n(selN), .register_bank_select(bank),
    .host_data_in(dIn), .host_data_out(dOut), .host_data_oe(dOe), .dma_request_out(dreq),
    .dma_grant_in_n(gntN), .module_present_n(prN), .irq_line_zero(irq0),
    .irq_line_one(irq1), .parity_option_line(par), .test_clock_option_line(tclk),
    .dmaJumper(jmp), .ctrlBusy(busy), .ctrlXferRequest(xreq), .ctrlDoneEvt(evt[2]),
    .ctrlFailEvt(evt[1]), .ctrlErrEvt(evt[0]), .ctrlRdData(rdData), .ninthDataBit(nb),
    .ctrlCmdPulse(cmdP), .ctrlCmdCode(cmdCode), .ctrlRegWr(regWr), .ctrlRegRd(regRd),
    .ctrlRegIdx(idx), .ctrlRegWrData(wrD));
  // Pulse capture and hang guard
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    nCmd <= nCmd + int'(cmdP === 1'b1);
    nWr <= nWr + int'(regWr === 1'b1);
    if (cmdP === 1'b1)
      lastCmd <= cmdCode;
    if (regWr === 1'b1)
      lastWr <= {idx, wrD};
    if (regRd === 1'b1)
      lastRd <= idx;
    if (cycles == 6000)
    begin
      mismatches++;
      results();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wr(input logic a0, input bbhp_byte_t v);
    hostU.hostWrite(a0, 1'b0, v);
  endtask
  task automatic rd(input logic a0);
    hostU.hostRead(a0, 1'b0, 1'b0, d, ok, rq);
    `CHK("answered", 1'b1, ok)
  endtask
  task automatic fire(input int k);
    evt = 3'b100 >> k;
    cyc(1);
    evt = 3'b000;
    cyc(2);
  endtask
  task automatic tStatic;
    nb = 1'b1;
    t = tclk;
    cyc(1);
    `CHK("present", 1'b0, prN)
    `CHK("irq one", 1'b0, irq1)
    `CHK("oe", 1'b0, dOe)
    `CHK("dreq", 1'b0, dreq)
    `CHK("parity", 1'b1, par)
    `CHK("tclk", 1'b1, t ^ tclk)
    wr(1'b1, `BBHP_CMD_ABORT);
    `CHK("power abort", `BBHP_CMD_ABORT, lastCmd)
    $display("tStatic done");
  endtask
  task automatic tRegs;
    int n0;
    wr(1'b1, 8'h0B);
    wr(1'b0, 8'h00);
    `CHK("wr idx", 12'hB00, lastWr)
    wr(1'b0, 8'h33);
    `CHK("wr next", 12'hC33, lastWr)
    n0 = nWr;
    hostU.hostWrite(1'b0, 1'b1, 8'h77);
    `CHK("deselected", n0, nWr)
    hostU.hostRead(1'b1, 1'b0, 1'b1, d, ok, rq);
    `CHK("deselected rd", 1'b0, ok)
    busy = 1'b1;
    xreq = 1'b1;
    rd(1'b1);
    `CHK("status", 8'h88, d)
    busy = 1'b0;
    xreq = 1'b0;
    wr(1'b1, 8'h00);
    rdData = 8'hA5;
    for (int b = 0; b < 2; b++)
    begin
      rd(1'b0);
      `CHK("fifo", 8'hA5, d)
      `CHK("fifo idx", 4'h0, lastRd)
    end
    $display("tRegs done");
  endtask
  task automatic tCmds;
    int n0;
    busy = 1'b1;
    n0 = nCmd;
    wr(1'b1, 8'h12);
    `CHK("busy cmd", n0, nCmd)
    wr(1'b1, `BBHP_CMD_ABORT);
    `CHK("abort", `BBHP_CMD_ABORT, lastCmd)
    `CHK("abort taken", n0 + 1, nCmd)
    fire(0);
    rd(1'b1);
    `CHK("busy done", 8'hC0, d)
    busy = 1'b0;
    wr(1'b1, 8'h12);
    `CHK("idle cmd", 8'h12, lastCmd)
    wr(1'b1, 8'h03);
    rd(1'b1);
    `CHK("done", 8'h40, d)
    wr(1'b1, `BBHP_CMD_CLEAR_INT);
    `CHK("clear local", n0 + 2, nCmd)
    rd(1'b1);
    `CHK("cleared", 8'h00, d)
    rd(1'b0);
    `CHK("to fifo", 4'h0, lastRd)
    $display("tCmds done");
  endtask
  task automatic tIrq;
    for (int k = 0; k < 3; k++)
    begin
      wr(1'b1, 8'h0B);
      wr(1'b0, 8'h03);
      jmp = (k == 2);
      fire(k);
      `CHK("irq", k < 2, irq0)
      rd(1'b1);
      `CHK("cause", 8'h40 >> k, d)
      wr(1'b1, `BBHP_CMD_CLEAR_INT);
      `CHK("irq clr", 1'b0, irq0)
    end
    jmp = 1'b0;
    wr(1'b1, 8'h0B);
    wr(1'b0, 8'h08);
    xreq = 1'b1;
    cyc(2);
    `CHK("xreq irq", 1'b1, irq0)
    xreq = 1'b0;
    cyc(2);
    `CHK("xreq irq off", 1'b0, irq0)
    $display("tIrq done");
  endtask
  task automatic tDma;
    jmp = 1'b1;
    wr(1'b1, 8'h0B);
    wr(1'b0, 8'h00);
    xreq = 1'b1;
    cyc(3);
    `CHK("no dma", 1'b0, dreq)
    wr(1'b1, 8'h0B);
    wr(1'b0, 8'h04);
    `CHK("dma req", 1'b1, dreq)
    wr(1'b1, 8'h0B);
    rd(1'b0);
    `CHK("en read", 8'h04, d)
    `CHK("en idx", 4'hB, lastRd)
    rdData = 8'hC3;
    hostU.hostRead(1'b1, 1'b1, 1'b1, d, ok, rq);
    `CHK("dma answered", 1'b1, ok)
    `CHK("dma data", 8'hC3, d)
    `CHK("dma idx", 4'h0, lastRd)
    `CHK("req drop", 1'b0, rq)
    `CHK("req rearm", 1'b1, dreq)
    rst = 1'b1;
    cyc(2);
    `CHK("reset dreq", 1'b0, dreq)
    rst = 1'b0;
    cyc(2);
    `CHK("reset enable", 1'b0, dreq)
    xreq = 1'b0;
    $display("tDma done");
  endtask
  task automatic results;
    $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    cyc(16);
    rst = 1'b0;
    cyc(2);
    tStatic();
    tRegs();
    tCmds();
    tIrq();
    tDma();
    results();
  end
endmodule
`default_nettype wire
